// ==== hdl/tcc_consts.svh ====
// Constants for the timer capture compare block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_CLK_MHZ        100
`define TCC_TICK_SLOW_NS   1000
`define TCC_TICK_FAST_NS   500
`define TCC_TICK_SLOW_CYC  (`TCC_TICK_SLOW_NS * `TCC_CLK_MHZ / 1000)
`define TCC_TICK_FAST_CYC  (`TCC_TICK_FAST_NS * `TCC_CLK_MHZ / 1000)
`define TCC_TIMER_RESET    16'h0000
`define TCC_TIMER_W        16
`define TCC_PRESC_W        8
`endif

// ==== hdl/tcc_pkg.sv ====
// Types for the timer capture compare block
package tcc_pkg;
   typedef struct packed {
      logic [1:0]  sync1;
      logic [1:0]  sync2;
      logic [1:0]  prev;
      logic [15:0] cap0;
      logic [15:0] cap1;
   } capture_state_t;

   typedef struct packed {
      logic [7:0]  pend_high0;
      logic [7:0]  pend_high1;
      logic [15:0] cmp0;
      logic [15:0] cmp1;
      logic [1:0]  pin;
   } compare_state_t;

   typedef struct packed {
      logic [7:0]     presc;
      logic [15:0]    timer;
      logic [15:0]    snap;
      logic [1:0]     cap_flag;
      logic [1:0]     cmp_flag;
      capture_state_t cap;
      compare_state_t cmp;
   } tcc_state_t;

   typedef enum logic [1:0] {
      PIN_GPIO   = 2'b01,
      PIN_SERIAL = 2'b10
   } pin_owner_t;
endpackage

// ==== hdl/timer_capture_compare.sv ====
// Free running timer with two capture and two compare channels
`include "tcc_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// - 16-bit free running timer ticking every 1 us or 0.5 us by select bit
// - Own counter, shared time base for all capture and compare channels
// - Snapshot pair holds its value between requests
// - Snapshot request copies present timer count into snapshot pair
// - Capture activate bit switches the pin to capture use directly
// - Each capture triggers on rising or falling edge per select bit
// - Two capture channels, each with its own 16-bit register
// - Selected edge loads timer into capture register and raises interrupt
// - Compare activate bit hands the pin to the compare channel
// - Match level bit picks high or low drive at match
// - Two compare channels with software writable 16-bit registers
// - Equality drives pin to match level and raises channel interrupt
// - Compare action repeats at every equality, every wrap
// - Serial function beats capture/compare on the channel 1 pins only, which beats plain GPIO
// - Reset clears timer, flags, capture/compare registers and compare pins; capture and compare on follow the activate inputs
module timer_capture_compare
   import tcc_pkg::*;
#(
   parameter int TICK_SLOW_CYC = `TCC_TICK_SLOW_CYC,
   parameter int TICK_FAST_CYC = `TCC_TICK_FAST_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_timer_resolution_select,
   input  wire logic        i_timer_snapshot_request,
   input  wire logic [1:0]  i_capture_pin_activate,
   input  wire logic [1:0]  i_capture_edge_select,
   input  wire logic [1:0]  i_compare_pin_activate,
   input  wire logic        i_compare1_match_level,
   input  wire logic        i_compare2_match_level,
   input  wire logic [1:0]  i_serial_interface_select,
   input  wire logic [1:0]  i_compare_high_write,
   input  wire logic [1:0]  i_compare_low_write,
   input  wire logic [7:0]  i_compare_write_data,
   input  wire logic [1:0]  i_capture_ack,
   input  wire logic [1:0]  i_compare_ack,
   input  wire logic        i_capture_input_one,
   input  wire logic        i_capture_input_two,
   output logic [15:0]      o_timer_count,
   output logic [7:0]       o_timer_snapshot_high,
   output logic [7:0]       o_timer_snapshot_low,
   output logic [15:0]      o_capture_value_one,
   output logic [15:0]      o_capture_value_two,
   output logic [15:0]      o_compare_value_one,
   output logic [15:0]      o_compare_value_two,
   output logic [1:0]       o_capture_irq,
   output logic [1:0]       o_compare_irq,
   output logic [1:0]       o_capture_active,
   output logic [1:0]       o_compare_active,
   output logic             o_compare_output_one,
   output logic             o_compare_output_two,
   output logic             o_compare_oe_one,
   output logic             o_compare_oe_two
);
   ////////////////////////////////////////////////////////////////////////////////
   // State
   tcc_state_t s_q;
   tcc_state_t s_d;
   logic       serial_on;
   logic [1:0] cap_on;
   logic [1:0] cmp_on;
   logic [1:0] pins;
   logic [1:0] edge_hit;
   logic [1:0] match;
   logic [1:0] lvl;
   logic [7:0] tick_max;

   localparam logic [7:0] SLOW_MAX = 8'(TICK_SLOW_CYC - 1);
   localparam logic [7:0] FAST_MAX = 8'(TICK_FAST_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin ownership
   always_comb begin
      serial_on = (i_serial_interface_select == 2'h1);
      // Channel 1 pins share the serial function; channel 2 pins do not
      cap_on[0] = i_capture_pin_activate[0] & ~serial_on;
      cap_on[1] = i_capture_pin_activate[1];
      cmp_on[0] = i_compare_pin_activate[0] & ~serial_on;
      cmp_on[1] = i_compare_pin_activate[1];
      pins      = {s_q.cap.sync2[1], s_q.cap.sync2[0]};
      lvl       = {i_compare2_match_level, i_compare1_match_level};
      tick_max  = i_timer_resolution_select ? FAST_MAX : SLOW_MAX;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d = s_q;
      // Prescaler and timer
      if (s_q.presc >= tick_max) begin
         s_d.presc = 8'h00;
         s_d.timer = s_q.timer + 16'h0001;
      end else begin
         s_d.presc = s_q.presc + 8'h01;
      end
      if (i_timer_snapshot_request) begin
         s_d.snap = s_q.timer;
      end
      // Pin synchronisers
      s_d.cap.sync1 = {i_capture_input_two, i_capture_input_one};
      s_d.cap.sync2 = s_q.cap.sync1;
      s_d.cap.prev  = s_q.cap.sync2;
      for (int i = 0; i < 2; i++) begin
         // Edge select high picks rising, low picks falling
         edge_hit[i] = cap_on[i] & (i_capture_edge_select[i] ?
                       (pins[i] & ~s_q.cap.prev[i]) : (~pins[i] & s_q.cap.prev[i]));
         match[i]    = (i == 0 ? s_q.cmp.cmp0 : s_q.cmp.cmp1) == s_q.timer;
         // Set wins over acknowledge
         s_d.cap_flag[i] = edge_hit[i] | (s_q.cap_flag[i] & ~i_capture_ack[i]);
         s_d.cmp_flag[i] = (match[i] & cmp_on[i]) |
                           (s_q.cmp_flag[i] & ~i_compare_ack[i]);
         if (match[i] & cmp_on[i]) begin
            s_d.cmp.pin[i] = lvl[i];
         end
      end
      if (edge_hit[0]) s_d.cap.cap0 = s_q.timer;
      if (edge_hit[1]) s_d.cap.cap1 = s_q.timer;
      // Compare register writes, high byte pending until low byte
      if (i_compare_high_write[0]) s_d.cmp.pend_high0 = i_compare_write_data;
      if (i_compare_high_write[1]) s_d.cmp.pend_high1 = i_compare_write_data;
      if (i_compare_low_write[0])  s_d.cmp.cmp0 = {s_q.cmp.pend_high0, i_compare_write_data};
      if (i_compare_low_write[1])  s_d.cmp.cmp1 = {s_q.cmp.pend_high1, i_compare_write_data};
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_comb begin
      o_timer_count         = s_q.timer;
      o_timer_snapshot_high = s_q.snap[15:8];
      o_timer_snapshot_low  = s_q.snap[7:0];
      o_capture_value_one   = s_q.cap.cap0;
      o_capture_value_two   = s_q.cap.cap1;
      o_compare_value_one   = s_q.cmp.cmp0;
      o_compare_value_two   = s_q.cmp.cmp1;
      o_capture_irq         = s_q.cap_flag;
      o_compare_irq         = s_q.cmp_flag;
      o_capture_active      = cap_on;
      o_compare_active      = cmp_on;
      o_compare_output_one  = s_q.cmp.pin[0];
      o_compare_output_two  = s_q.cmp.pin[1];
      o_compare_oe_one      = cmp_on[0];
      o_compare_oe_two      = cmp_on[1];
   end
endmodule

// ==== bench/tcc_checker.sv ====
// Port assertions for the timer capture compare block
module tcc_checker (
   input wire logic        i_clk, i_rst, i_timer_snapshot_request, i_compare1_match_level, o_compare_output_one,
   input wire logic [1:0]  i_capture_pin_activate, o_capture_irq, o_compare_irq, o_capture_active, o_compare_active,
   input wire logic [7:0]  o_timer_snapshot_high, o_timer_snapshot_low,
   input wire logic [15:0] o_timer_count, o_capture_value_one, o_compare_value_one
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   snap_hold_a: assert property (!i_timer_snapshot_request |=> $stable({o_timer_snapshot_high, o_timer_snapshot_low}))
      else $error("snapshot moved");
   snap_load_a: assert property (i_timer_snapshot_request |=> {o_timer_snapshot_high, o_timer_snapshot_low}
      == $past(o_timer_count)) else $error("snapshot wrong");
   timer_step_a: assert property ($changed(o_timer_count) |-> o_timer_count == $past(o_timer_count) + 16'h1)
      else $error("timer jump");
   cap_load_a: assert property ($changed(o_capture_value_one) |-> o_capture_value_one == $past(o_timer_count))
      else $error("capture wrong");
   cap_irq_a: assert property ($changed(o_capture_value_one) |-> o_capture_irq[0]) else $error("no capture flag");
   cmp_level_a: assert property (o_compare_active[0] && o_compare_value_one == o_timer_count
      |=> o_compare_output_one == $past(i_compare1_match_level)) else $error("compare pin");
   cmp_irq_a: assert property (o_compare_active[0] && o_compare_value_one == o_timer_count
      |=> o_compare_irq[0]) else $error("no compare flag");
   cap_own_a: assert property (o_capture_active[1] == i_capture_pin_activate[1]) else $error("capture owner");
endmodule
bind timer_capture_compare tcc_checker tcc_checker_inst (.*);

// ==== bench/tcc_pin_source.sv ====
// Far-side source of the two capture pins
module tcc_pin_source (
   input  wire logic       i_clk,
   input  wire logic [1:0] i_want,
   output logic            o_one, o_two
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {o_two, o_one} = 2'h0;
   always @(posedge i_clk) #3 {o_two, o_one} <= i_want;
endmodule

// ==== bench/test_timer_capture_compare.sv ====
// Self-checking bench for the timer capture compare block
module test_timer_capture_compare;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk = 1'b0, i_rst, res, req, lvl, pin1, pin2, out1, out2, oe1, oe2;
   logic [1:0]  cap_act, edge_sel, cmp_act, ser, hw, lw, cack, mack, want, cirq, mirq, cav, mav, prev;
   logic [7:0]  wdat, sh, sl;
   logic [15:0] tcnt, cv1, cv2, mv1, mv2, rt, e;
   int          rp, n_errors = 0, compares = 0;
   logic [15:0] exp_q[$];
   timer_capture_compare #(.TICK_SLOW_CYC(8), .TICK_FAST_CYC(4)) timer_capture_compare_inst (.i_clk, .i_rst,
      .i_timer_resolution_select(res), .i_timer_snapshot_request(req), .i_capture_pin_activate(cap_act),
      .i_capture_edge_select(edge_sel), .i_compare_pin_activate(cmp_act), .i_compare1_match_level(lvl),
      .i_compare2_match_level(lvl), .i_serial_interface_select(ser), .i_compare_high_write(hw),
      .i_compare_low_write(lw), .i_compare_write_data(wdat), .i_capture_ack(cack), .i_compare_ack(mack),
      .i_capture_input_one(pin1), .i_capture_input_two(pin2), .o_timer_count(tcnt), .o_timer_snapshot_high(sh),
      .o_timer_snapshot_low(sl), .o_capture_value_one(cv1), .o_capture_value_two(cv2), .o_compare_value_one(mv1),
      .o_compare_value_two(mv2), .o_capture_irq(cirq), .o_compare_irq(mirq), .o_capture_active(cav),
      .o_compare_active(mav), .o_compare_output_one(out1), .o_compare_output_two(out2), .o_compare_oe_one(oe1),
      .o_compare_oe_two(oe2));
   tcc_pin_source tcc_pin_source_inst (.i_clk, .i_want(want), .o_one(pin1), .o_two(pin2));
   initial forever #5 i_clk = ~i_clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      n_errors += int'(seen !== exp);
      if (seen !== exp) $display("unexpected at %0t: %h vs %h", $time, seen, exp);
   endtask
   task automatic end_of_test;
      $display("mismatches %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic await(input int b);
      int w;
      for (w = 0; w < 300 && (({mirq, cirq} >> b) & 4'h1) !== 4'h1; w++) @(posedge i_clk);
      n_errors += int'(w == 300);
      if (w == 300) end_of_test;
   endtask
   always @(posedge i_clk) begin
      rp <= (i_rst || rp == (res ? 3 : 7)) ? 0 : rp + 1;
      rt <= i_rst ? 16'h0 : rt + 16'(rp == (res ? 3 : 7));
      prev <= cirq;
      for (int k = 0; k < 2; k++)
         if (cirq[k] === 1'b1 && prev[k] !== 1'b1) check(k ? cv2 : cv1, exp_q.pop_front());
   end
   initial begin
      {i_rst, res, req, lvl, cap_act, edge_sel, cmp_act, ser, hw, lw, cack, mack, want, wdat} = {1'b1, 29'h0};
      void'($urandom(32'h2bf3d4c6));
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (41) @(posedge i_clk);
      check({cav, mav, cirq, mirq, oe1, oe2}, 16'h0);
      check(tcnt, rt);
      req <= 1'b1;
      @(posedge i_clk);
      req <= 1'b0;
      e = rt;
      repeat (20) @(posedge i_clk);
      check({sh, sl}, e);
      cap_act <= 2'h3;
      for (int k = 0; k < 4; k++) begin
         edge_sel <= {2{k[1]}};
         want[k[0]] <= ~k[1];
         repeat (9) @(posedge i_clk);
         for (int w = 0; w < 9 && rp != 1; w++) @(posedge i_clk);
         exp_q.push_back(rt);
         want[k[0]] <= k[1];
         await(k[0]);
         cack[k[0]] <= 1'b1;
         @(posedge i_clk);
         cack <= 2'h0;
      end
      ser <= 2'h1;
      @(posedge i_clk);
      check({cav, mav[0]}, 3'h4);
      {ser, cmp_act} <= 4'h3;
      for (int k = 0; k < 4; k++) begin
         lvl <= ~k[1];
         e = rt + 16'h2 + 16'($urandom_range(3));
         {wdat, hw[k[0]]} <= {e[15:8], 1'b1};
         @(posedge i_clk);
         {wdat, hw, lw[k[0]]} <= {e[7:0], 2'h0, 1'b1};
         @(posedge i_clk);
         lw <= 2'h0;
         @(posedge i_clk);
         check(k[0] ? mv2 : mv1, e);
         await(2 + k[0]);
         check(k[0] ? out2 : out1, 16'(!k[1]));
         check({oe2, oe1}, 16'h3);
         repeat (9) @(posedge i_clk);
         mack[k[0]] <= 1'b1;
         @(posedge i_clk);
         mack <= 2'h0;
         @(posedge i_clk);
         check(16'(mirq), 16'h0);
      end
      check(16'(exp_q.size()), 16'h0);
      {i_rst, res} <= 2'h3;
      @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (40) @(posedge i_clk);
      check(tcnt, rt);
      end_of_test;
   end
endmodule
